// *** design/fpsc_pkg.sv ***
// fpsc_pkg: constants for the host-side flash protect / secured sector controller
// assumes a byte-wide parallel nor flash outside, driven by fpsc_host
package fpsc_pkg;
    // command codes
    localparam logic [7:0] CMD_UNLOCK1 = 8'hAA;
    localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
    localparam logic [7:0] CMD_SEC_ENTER = 8'h88;
    localparam logic [7:0] CMD_AUTOSEL = 8'h90;
    localparam logic [7:0] CMD_SEC_EXIT = 8'h00;
    localparam logic [7:0] CMD_RESET = 8'hF0;
    localparam logic [7:0] CMD_SUSPEND = 8'hB0;
    localparam logic [7:0] CMD_RESUME = 8'h30;
    // unlock addresses (low bits only are decoded)
    localparam logic [22:0] ADDR_UNLOCK1 = 23'h000555;
    localparam logic [22:0] ADDR_UNLOCK2 = 23'h0002AA;
    // protect verify answers
    localparam logic [7:0] PROT_YES = 8'h01;
    localparam logic [7:0] PROT_NO = 8'h00;
    localparam int SECTOR_LSB = 16;
    localparam int SECTOR_MSB = 21;
    localparam int TOP_DATA_BIT = 7;
    // timing
    localparam int CLK_NS = 50;
    localparam int GLITCH_NS = 5;
    localparam int PULSE_NS = 100;
    localparam int PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int SETUP_NS = 50;
    localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int READ_NS = 120;
    localparam int READ_CYC = (READ_NS + CLK_NS - 1) / CLK_NS;
    // host operations
    localparam logic [2:0] OP_READ = 3'h0;
    localparam logic [2:0] OP_WRITE = 3'h1;
    localparam logic [2:0] OP_RESET = 3'h2;
    localparam logic [2:0] OP_SEC_ENTER = 3'h3;
    localparam logic [2:0] OP_SEC_EXIT = 3'h4;
    localparam logic [2:0] OP_PROT_VERIFY = 3'h5;
    localparam logic [2:0] OP_SUSPEND = 3'h6;
    localparam logic [2:0] OP_RESUME = 3'h7;
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_SETUP = 5'b00010,
        ST_PULSE = 5'b00100,
        ST_HOLD = 5'b01000,
        ST_READ = 5'b10000
    } fpsc_state_t;
endpackage

// *** design/fpsc_host.sv ***
// fpsc_host: host controller that drives the flash bus pins for protect and
// secured-sector operations; one bus cycle per state pass.
// assumes the flash answers within READ_NS and strobes are sampled by the flash.
//
// Contract
// - protect verify: high voltage on bit nine, a1 high, a0/a6 low, sector bits 16-21
// - lock: three-cycle enter sequence then protect algorithm; fpsc_host issues the enter sequence but has no protect algorithm operation
// - host writes exit sequence before touching rest of array
// - write only with select and strobe low, output enable high
`timescale 1ns/1ps
`default_nettype none
module fpsc_host #(
    parameter int PULSE_CYC = fpsc_pkg::PULSE_CYC,
    parameter int READ_CYC = fpsc_pkg::READ_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic req_valid,
    input wire logic [2:0] req_op,
    input wire logic [22:0] req_addr,
    input wire logic [7:0] req_data,
    input wire logic erase_active,
    output logic req_ready,
    output logic rsp_valid,
    output logic [7:0] rsp_data,
    output logic sec_mode,
    output logic [22:0] flash_addr,
    output logic [7:0] flash_dq_out,
    output logic flash_dq_oe,
    input wire logic [7:0] flash_dq_in,
    output logic flash_ce_n,
    output logic flash_oe_n,
    output logic flash_we_n,
    output logic flash_reset_n,
    output logic hv_on_a9
);
    fpsc_pkg::fpsc_state_t state_q;
    logic [7:0] cnt_q;
    logic [1:0] step_q;
    logic [1:0] nsteps_q;
    logic [2:0] op_q;
    logic [22:0] addr_q;
    logic [7:0] data_q;
    logic is_read;
    logic [22:0] step_addr;
    logic [7:0] step_data;

    ////////////////////////////////////////////////////////////////////////
    // sequence table per operation and step
    always_comb
    begin
        step_addr = addr_q;
        step_data = data_q;
        is_read = 1'b0;
        case (op_q)
            fpsc_pkg::OP_READ:
            begin
                is_read = 1'b1;
            end
            fpsc_pkg::OP_RESET:
            begin
                step_data = fpsc_pkg::CMD_RESET;
            end
            fpsc_pkg::OP_SUSPEND:
            begin
                step_data = fpsc_pkg::CMD_SUSPEND;
            end
            fpsc_pkg::OP_RESUME:
            begin
                step_data = fpsc_pkg::CMD_RESUME;
            end
            fpsc_pkg::OP_PROT_VERIFY:
            begin
                is_read = 1'b1;
                step_addr = 23'h000000;
                step_addr[fpsc_pkg::SECTOR_MSB:fpsc_pkg::SECTOR_LSB] =
                    addr_q[fpsc_pkg::SECTOR_MSB:fpsc_pkg::SECTOR_LSB];
                step_addr[1] = 1'b1;
            end
            fpsc_pkg::OP_SEC_ENTER, fpsc_pkg::OP_SEC_EXIT:
            begin
                case (step_q)
                    2'h0:
                    begin
                        step_addr = fpsc_pkg::ADDR_UNLOCK1;
                        step_data = fpsc_pkg::CMD_UNLOCK1;
                    end
                    2'h1:
                    begin
                        step_addr = fpsc_pkg::ADDR_UNLOCK2;
                        step_data = fpsc_pkg::CMD_UNLOCK2;
                    end
                    2'h2:
                    begin
                        step_addr = fpsc_pkg::ADDR_UNLOCK1;
                        step_data = (op_q == fpsc_pkg::OP_SEC_ENTER) ?
                            fpsc_pkg::CMD_SEC_ENTER : fpsc_pkg::CMD_AUTOSEL;
                    end
                    default:
                    begin
                        step_addr = 23'h000000;
                        step_data = fpsc_pkg::CMD_SEC_EXIT;
                    end
                endcase
            end
            default:
            begin
                is_read = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // bus cycle sequencer
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_q <= fpsc_pkg::ST_IDLE;
            cnt_q <= 8'h00;
            step_q <= 2'h0;
            nsteps_q <= 2'h0;
            op_q <= fpsc_pkg::OP_READ;
            addr_q <= 23'h000000;
            data_q <= 8'h00;
        end
        else
        begin
            case (state_q)
                fpsc_pkg::ST_IDLE:
                begin
                    // suspend or resume dropped unless an erase runs
                    if (req_valid && (erase_active || (req_op != fpsc_pkg::OP_SUSPEND &&
                        req_op != fpsc_pkg::OP_RESUME)))
                    begin
                        op_q <= req_op;
                        addr_q <= req_addr;
                        data_q <= req_data;
                        step_q <= 2'h0;
                        nsteps_q <= (req_op == fpsc_pkg::OP_SEC_ENTER) ? 2'h2 :
                            (req_op == fpsc_pkg::OP_SEC_EXIT) ? 2'h3 : 2'h0;
                        cnt_q <= 8'h00;
                        state_q <= fpsc_pkg::ST_SETUP;
                    end
                end
                fpsc_pkg::ST_SETUP:
                begin
                    state_q <= fpsc_pkg::ST_PULSE;
                    cnt_q <= 8'h00;
                end
                fpsc_pkg::ST_PULSE:
                begin
                    // strobe held far past glitch width
                    if (int'(cnt_q) >= (is_read ? READ_CYC : PULSE_CYC) - 1)
                    begin
                        state_q <= is_read ? fpsc_pkg::ST_READ : fpsc_pkg::ST_HOLD;
                    end
                    cnt_q <= cnt_q + 8'h01;
                end
                fpsc_pkg::ST_HOLD:
                begin
                    // full sequence issued back to back
                    if (step_q != nsteps_q)
                    begin
                        step_q <= step_q + 2'h1;
                        state_q <= fpsc_pkg::ST_SETUP;
                    end
                    else
                    begin
                        state_q <= fpsc_pkg::ST_IDLE;
                    end
                end
                fpsc_pkg::ST_READ:
                begin
                    state_q <= fpsc_pkg::ST_IDLE;
                end
                default:
                begin
                    state_q <= fpsc_pkg::ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pins; address set in setup so it is stable before the strobe falls
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            flash_addr <= 23'h000000;
            flash_dq_out <= 8'h00;
            flash_dq_oe <= 1'b0;
            flash_ce_n <= 1'b1;
            flash_oe_n <= 1'b1;
            flash_we_n <= 1'b1;
            hv_on_a9 <= 1'b0;
        end
        else
        begin
            flash_addr <= step_addr;
            flash_dq_out <= step_data;
            // write with ce and we low, oe high
            // we falls after ce and address stable
            // we rises while ce still low, data latched then
            flash_ce_n <= (state_q == fpsc_pkg::ST_IDLE || state_q == fpsc_pkg::ST_READ);
            flash_we_n <= !(state_q == fpsc_pkg::ST_PULSE && !is_read);
            flash_oe_n <= !(state_q == fpsc_pkg::ST_PULSE && is_read);
            flash_dq_oe <= (state_q != fpsc_pkg::ST_IDLE && state_q != fpsc_pkg::ST_READ)
                && !is_read;
            // high voltage on bit nine only during verify
            hv_on_a9 <= (state_q == fpsc_pkg::ST_SETUP || state_q == fpsc_pkg::ST_PULSE)
                && op_q == fpsc_pkg::OP_PROT_VERIFY;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // answers and tracked secured-sector mode
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rsp_valid <= 1'b0;
            rsp_data <= 8'h00;
            sec_mode <= 1'b0;
            req_ready <= 1'b0;
            flash_reset_n <= 1'b0;
        end
        else
        begin
            flash_reset_n <= 1'b1;
            req_ready <= (state_q == fpsc_pkg::ST_IDLE) && !req_valid;
            rsp_valid <= (state_q == fpsc_pkg::ST_READ) ||
                (state_q == fpsc_pkg::ST_HOLD && step_q == nsteps_q);
            if (state_q == fpsc_pkg::ST_READ)
            begin
                rsp_data <= flash_dq_in;
            end
            // mode flag follows enter and exit, not the reset code
            // only rst or exit clear it; the reset code leaves secured mode on
            if (state_q == fpsc_pkg::ST_HOLD && step_q == nsteps_q)
            begin
                if (op_q == fpsc_pkg::OP_SEC_ENTER)
                    sec_mode <= 1'b1;
                else if (op_q == fpsc_pkg::OP_SEC_EXIT)
                    sec_mode <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // no write strobe with output enable low
    write_inhibit_a: assert property (@(posedge clk) disable iff (rst)
        !flash_we_n |-> (!flash_ce_n && flash_oe_n)) else $error("write with oe low");
    sequence we_fall_s;
        $fell(flash_we_n);
    endsequence
    pulse_width_a: assert property (@(posedge clk) disable iff (rst)
        we_fall_s |=> !flash_we_n) else $error("write pulse too short");
    data_latch_a: assert property (@(posedge clk) disable iff (rst)
        $rose(flash_we_n) |-> !flash_ce_n) else $error("ce rose with we");
    addr_stable_a: assert property (@(posedge clk) disable iff (rst)
        $fell(flash_we_n) |-> $stable(flash_addr)) else $error("address moved at strobe");
    // high voltage only with a1 set, a0 a6 low
    verify_pins_a: assert property (@(posedge clk) disable iff (rst)
        hv_on_a9 |-> (flash_addr[1] && !flash_addr[0] && !flash_addr[6] && flash_we_n))
        else $error("bad verify pins");
    enter_mode_a: assert property (@(posedge clk) disable iff (rst)
        (state_q == fpsc_pkg::ST_HOLD && step_q == nsteps_q
        && op_q == fpsc_pkg::OP_SEC_ENTER) |=> sec_mode) else $error("mode not set");
    exit_mode_a: assert property (@(posedge clk) disable iff (rst)
        (state_q == fpsc_pkg::ST_HOLD && step_q == nsteps_q
        && op_q == fpsc_pkg::OP_SEC_EXIT) |=> !sec_mode) else $error("mode not cleared");
    suspend_gate_a: assert property (@(posedge clk) disable iff (rst)
        (state_q == fpsc_pkg::ST_IDLE && req_valid && !erase_active
        && req_op == fpsc_pkg::OP_SUSPEND) |=> state_q == fpsc_pkg::ST_IDLE)
        else $error("suspend issued without erase");
endmodule
`default_nettype wire

// *** dv/fpsc_flash_model.sv ***
// fpsc_flash_model: behavioural byte-wide nor flash answering fpsc_host
// assumes active-low strobes from the host and a bus resolved by the bench
`timescale 1ns/1ps
`default_nettype none
module fpsc_flash_model #(
    parameter logic [15:0] PROT_GROUPS = 16'h0005,
    parameter bit FACTORY = 1'b1
) (
    input wire logic [22:0] addr,
    input wire logic [7:0] dq,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic reset_n,
    input wire logic hv_a9,
    output logic [7:0] dev_dq,
    output logic sec,
    output int wr_count,
    output logic [22:0] lat_addr,
    output logic [7:0] lat_data
);
    logic [1:0] stage = 2'h0;
    logic [7:0] rd_val;
    logic [7:0] last = 8'h00;
    logic drive;
    logic armed = 1'b0;
    realtime t_low;
    initial sec = 1'b0;
    initial wr_count = 0;
    ////////////////////////////////////////////////////////////////////////////
    // reset pin forces array read
    always @(negedge reset_n)
    begin
        stage = 2'h0;
        sec = 1'b0;
    end
    always @(negedge ce_n or negedge we_n)
    begin
        if (!ce_n && !we_n && oe_n && reset_n)
        begin
            lat_addr = addr;
            t_low = $realtime;
            armed = 1'b1;
        end
    end
    // data on first rise, glitches ignored
    always @(posedge ce_n or posedge we_n)
    begin
        if (armed && reset_n && ($realtime - t_low) >= 5.0)
        begin
            lat_data = dq;
            wr_count++;
            if (dq == 8'hF0)
                stage = 2'h0;
            else if (stage == 2'h0)
                stage = (dq == 8'hAA && lat_addr[10:0] == 11'h555) ? 2'h1 : 2'h0;
            else if (stage == 2'h1)
                stage = (dq == 8'h55 && lat_addr[10:0] == 11'h2AA) ? 2'h2 : 2'h0;
            else if (stage == 2'h2)
            begin
                sec = sec | (dq == 8'h88 && lat_addr[10:0] == 11'h555);
                stage = (dq == 8'h90 && lat_addr[10:0] == 11'h555) ? 2'h3 : 2'h0;
            end
            else
            begin
                sec = sec & (dq != 8'h00);
                stage = 2'h0;
            end
        end
        armed = 1'b0;
    end
    // read path; released bus shows inverse of last byte
    always @*
    begin
        drive = reset_n && !ce_n && !oe_n && we_n;
        if (hv_a9)
            rd_val = (addr[1] && !addr[0] && !addr[6]) ? {7'h00, PROT_GROUPS[addr[21:18]]} : 8'hFF;
        // fixed lock indicator on the top bit while in id mode
        else if (stage == 2'h3)
            rd_val = (addr[7:0] == 8'h03) ? {FACTORY, 7'h00} : 8'h00;
        else if (sec && addr[22:15] == 8'h00)
            rd_val = (FACTORY && addr[7:4] == 4'h0) ? (8'hA5 ^ addr[7:0]) : 8'hFF;
        else
            rd_val = addr[7:0] ^ 8'h3C;
        if (drive)
            last = rd_val;
        dev_dq = drive ? rd_val : ~last;
    end
endmodule
`default_nettype wire

// *** dv/fpsc_tb_top.sv ***
// fpsc_tb_top: directed tests of fpsc_host against the flash model
// assumes default timing parameters of fpsc_host
`timescale 1ns/1ps
`default_nettype none
module fpsc_tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic req_valid = 1'b0;
    logic [2:0] req_op = 3'h0;
    logic [22:0] req_addr = 23'h000000;
    logic [7:0] req_data = 8'h00;
    logic erase_active = 1'b0;
    logic req_ready, rsp_valid, sec_mode, flash_dq_oe, ce_n, oe_n, we_n, reset_n, hv, sec;
    logic [7:0] rsp_data, flash_dq_out, dev_dq, dq_bus, lat_data, rd;
    logic [22:0] flash_addr, lat_addr;
    int wr_count, n_mismatch = 0, checked = 0, base;
    bit got;
    assign dq_bus = flash_dq_oe ? flash_dq_out : dev_dq;
    always #25 clk = ~clk;
    fpsc_host DUT (.clk(clk), .rst(rst), .req_valid(req_valid), .req_op(req_op),
        .req_addr(req_addr), .req_data(req_data), .erase_active(erase_active),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .sec_mode(sec_mode),
        .flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
        .flash_dq_in(dq_bus), .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
        .flash_reset_n(reset_n), .hv_on_a9(hv));
    fpsc_flash_model flash (.addr(flash_addr), .dq(dq_bus), .ce_n(ce_n), .oe_n(oe_n),
        .we_n(we_n), .reset_n(reset_n), .hv_a9(hv), .dev_dq(dev_dq), .sec(sec),
        .wr_count(wr_count), .lat_addr(lat_addr), .lat_data(lat_data));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // request held until the answer pulse or the wait runs out
    task automatic do_op(input logic [2:0] op, input logic [22:0] a, input logic [7:0] d);
        got = 1'b0;
        @(negedge clk);
        req_op = op;
        req_addr = a;
        req_data = d;
        req_valid = 1'b1;
        for (int n = 0; n < 40 && !got; n++)
        begin
            @(negedge clk);
            got = (rsp_valid === 1'b1);
        end
        rd = rsp_data;
        req_valid = 1'b0;
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk(reset_n, 1'b1);
        chk(sec_mode, 1'b0);
        chk(we_n, 1'b1);
        chk({ce_n, oe_n, flash_dq_oe, hv}, 4'hC);
        chk(req_ready, 1'b1);
        $display("t_reset done");
    endtask
    task automatic t_verify();
        do_op(3'h5, 23'h040000, 8'h00);
        chk(rd, 8'h00);
        do_op(3'h5, 23'h080000, 8'h00);
        chk({got, rd}, 9'h101);
        chk(hv, 1'b0);
        $display("t_verify done");
    endtask
    task automatic t_secured();
        do_op(3'h3, 23'h000000, 8'h00);
        chk({sec_mode, sec}, 2'b11);
        do_op(3'h0, 23'h000003, 8'h00);
        chk(rd, 8'hA6);
        do_op(3'h4, 23'h000000, 8'h00);
        chk({sec_mode, sec}, 2'b00);
        do_op(3'h0, 23'h000003, 8'h00);
        chk(rd, 8'h3F);
        do_op(3'h3, 23'h000000, 8'h00);
        do_op(3'h2, 23'h000000, 8'h00);
        chk({sec_mode, sec, lat_data}, 10'h3F0);
        do_op(3'h4, 23'h000000, 8'h00);
        $display("t_secured done");
    endtask
    task automatic t_write();
        base = wr_count;
        do_op(3'h1, 23'h012345, 8'h5A);
        chk(lat_addr, 23'h012345);
        chk(lat_data, 8'h5A);
        chk(wr_count, base + 1);
        $display("t_write done");
    endtask
    task automatic t_suspend();
        base = wr_count;
        do_op(3'h6, 23'h000000, 8'h00);
        chk(got, 1'b0);
        chk(wr_count, base);
        erase_active = 1'b1;
        do_op(3'h6, 23'h000000, 8'h00);
        chk({got, lat_data}, 9'h1B0);
        do_op(3'h7, 23'h000000, 8'h00);
        chk({got, lat_data}, 9'h130);
        erase_active = 1'b0;
        $display("t_suspend done");
    endtask
    task automatic t_indicator();
        do_op(3'h1, 23'h000555, 8'hAA);
        do_op(3'h1, 23'h0002AA, 8'h11);
        do_op(3'h0, 23'h000003, 8'h00);
        chk(rd, 8'h3F);
        do_op(3'h1, 23'h000555, 8'hAA);
        do_op(3'h1, 23'h0002AA, 8'h55);
        do_op(3'h1, 23'h000555, 8'h90);
        do_op(3'h0, 23'h000003, 8'h00);
        chk(rd, 8'h80);
        do_op(3'h2, 23'h000000, 8'h00);
        $display("t_indicator done");
    endtask
    initial
    begin
        repeat (20) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        t_reset();
        t_verify();
        t_secured();
        t_write();
        t_suspend();
        t_indicator();
        give_verdict();
    end
    initial
    begin
        repeat (3000) @(posedge clk);
        n_mismatch++;
        give_verdict();
    end
endmodule
`default_nettype wire
